// ===== include/sram_ctrl_pkg.sv
// Constants for the asynchronous static RAM controller
`default_nettype none
package sram_ctrl_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_PS = 10000;
    // Memory timing figures in picoseconds
    localparam int READ_CYCLE_TIME_PS = 10000;
    localparam int WRITE_PULSE_PS = 7000;
    localparam int WRITE_DATA_SETUP_TIME_PS = 5000;
    localparam int WRITE_STROBE_FLOAT_DELAY_PS = 5000;
    localparam int DATA_HOLD_PS = 0;
    localparam int DESELECT_TO_RETENTION_TIME_PS = 0;
    localparam int RETENTION_RECOVERY_TIME_PS = READ_CYCLE_TIME_PS;
    localparam int OE_TO_FLOAT_PS = 5000;
    // Cycle counts, least times rounded up to whole cycles, with no floor of one cycle
    localparam int READ_CYCLES =
        (READ_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYCLES_RAW =
        (WRITE_STROBE_FLOAT_DELAY_PS + WRITE_DATA_SETUP_TIME_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int WRITE_PULSE_CYCLES =
        (WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYCLES =
        (WRITE_CYCLES_RAW > WRITE_PULSE_CYCLES) ? WRITE_CYCLES_RAW : WRITE_PULSE_CYCLES;
    localparam int TURN_CYCLES =
        (OE_TO_FLOAT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVERY_CYCLES =
        (RETENTION_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYCLES);
    localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYCLES);
    localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYCLES);
    localparam logic [CNT_W-1:0] RECOVERY_CNT = CNT_W'(RECOVERY_CYCLES);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_TURN = 3'b010,
        ST_WRITE = 3'b011,
        ST_HOLD = 3'b100,
        ST_RETAIN = 3'b101,
        ST_RECOVER = 3'b110
    } state_t;
endpackage
`default_nettype wire

// ===== src/sync3.sv
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    // Update only once two stages agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/sram_ctrl.sv
// Synchronous controller driving an asynchronous 256K x 16 static RAM
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    // User side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [17:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic [1:0] req_lane_n,
    output logic req_ready,
    output logic [15:0] rsp_rdata,
    output logic rsp_valid,
    input wire logic retain_req,
    output logic retain_ok,
    // Memory pins
    output logic [17:0] mem_addr,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    output logic low_byte_lane_n,
    output logic high_byte_lane_n,
    input wire logic [15:0] mem_data_in,
    output logic [15:0] mem_data_out,
    output logic [15:0] mem_data_oe
);
    sram_ctrl_pkg::state_t state;
    logic [sram_ctrl_pkg::CNT_W-1:0] count;
    logic [15:0] data_sync;

    // ****************************************
    // Data input synchroniser
    // ****************************************
    sync3 #(
        .WIDTH(sram_ctrl_pkg::DATA_W)
    ) u_data_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .din(mem_data_in),
        .dout(data_sync)
    );

    // ****************************************
    // Access sequencer
    // ****************************************
    // Reads hold the pins for extra cycles so the synchronised data settles
    // before sampling; costs latency, avoids sampling a moving bus.
    localparam logic [sram_ctrl_pkg::CNT_W-1:0] READ_HOLD =
        sram_ctrl_pkg::READ_CNT + sram_ctrl_pkg::CNT_W'(4);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= sram_ctrl_pkg::ST_IDLE;
            count <= '0;
        end else begin
            unique case (state)
                sram_ctrl_pkg::ST_IDLE: begin
                    count <= '0;
                    if (retain_req) begin
                        state <= sram_ctrl_pkg::ST_RETAIN;
                    end else if (req_valid) begin
                        if (req_write) begin
                            state <= sram_ctrl_pkg::ST_WRITE;
                        end else begin
                            state <= sram_ctrl_pkg::ST_READ;
                        end
                    end
                end
                sram_ctrl_pkg::ST_READ: begin
                    count <= count + 1'b1;
                    if (count == READ_HOLD - 1'b1) begin
                        state <= sram_ctrl_pkg::ST_TURN;
                        count <= '0;
                    end
                end
                sram_ctrl_pkg::ST_TURN: begin
                    // Memory output floats before anyone drives again
                    count <= count + 1'b1;
                    if (count == sram_ctrl_pkg::TURN_CNT - 1'b1) begin
                        state <= sram_ctrl_pkg::ST_IDLE;
                        count <= '0;
                    end
                end
                sram_ctrl_pkg::ST_WRITE: begin
                    count <= count + 1'b1;
                    if (count == sram_ctrl_pkg::WRITE_CNT - 1'b1) begin
                        state <= sram_ctrl_pkg::ST_HOLD;
                        count <= '0;
                    end
                end
                sram_ctrl_pkg::ST_HOLD: begin
                    state <= sram_ctrl_pkg::ST_IDLE;
                end
                sram_ctrl_pkg::ST_RETAIN: begin
                    if (!retain_req) begin
                        state <= sram_ctrl_pkg::ST_RECOVER;
                        count <= '0;
                    end
                end
                sram_ctrl_pkg::ST_RECOVER: begin
                    count <= count + 1'b1;
                    if (count == sram_ctrl_pkg::RECOVERY_CNT - 1'b1) begin
                        state <= sram_ctrl_pkg::ST_IDLE;
                        count <= '0;
                    end
                end
                default: begin
                    state <= sram_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Memory pins
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem_addr <= '0;
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            low_byte_lane_n <= 1'b1;
            high_byte_lane_n <= 1'b1;
            mem_data_out <= '0;
            mem_data_oe <= '0;
        end else if (state == sram_ctrl_pkg::ST_IDLE && req_valid && !retain_req) begin
            mem_addr <= req_addr;
            chip_select_n <= 1'b0;
            low_byte_lane_n <= req_lane_n[0];
            high_byte_lane_n <= req_lane_n[1];
            write_strobe_n <= !req_write;
            output_gate_n <= req_write;
            mem_data_out <= req_wdata;
            mem_data_oe <= {16{req_write}};
        end else if (state == sram_ctrl_pkg::ST_WRITE &&
                     count == sram_ctrl_pkg::WRITE_CNT - 1'b1) begin
            // Strobe alone ends the write; select rises a cycle later
            write_strobe_n <= 1'b1;
        end else if (state == sram_ctrl_pkg::ST_HOLD) begin
            chip_select_n <= 1'b1;
            mem_data_oe <= '0;
            low_byte_lane_n <= 1'b1;
            high_byte_lane_n <= 1'b1;
        end else if (state == sram_ctrl_pkg::ST_READ &&
                     count == READ_HOLD - 1'b1) begin
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            low_byte_lane_n <= 1'b1;
            high_byte_lane_n <= 1'b1;
        end
    end

    // ****************************************
    // User answers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state == sram_ctrl_pkg::ST_READ && count == READ_HOLD - 1'b1) begin
                rsp_valid <= 1'b1;
                // Floating lanes read as zero
                rsp_rdata <= data_sync &
                    {{8{!high_byte_lane_n}}, {8{!low_byte_lane_n}}};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_ready <= 1'b0;
            retain_ok <= 1'b0;
        end else begin
            req_ready <= (state == sram_ctrl_pkg::ST_IDLE) && !req_valid && !retain_req;
            // Select is already high in this state
            retain_ok <= (state == sram_ctrl_pkg::ST_RETAIN) && retain_req;
        end
    end
endmodule
`default_nettype wire

// ===== verif/sram_ctrl_asserts.sv
// Pin protocol checks for the static RAM controller
`timescale 1ns/1ps
`default_nettype none
// ************
// Pin checker
// ************
module sram_ctrl_asserts (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rsp_valid,
    input wire logic retain_ok,
    input wire logic [17:0] mem_addr,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic [15:0] mem_data_out,
    input wire logic [15:0] mem_data_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_read_hold;
        (!output_gate_n && !chip_select_n && write_strobe_n) [*5];
    endsequence
    sequence s_write_end;
        write_strobe_n && !chip_select_n && mem_data_oe != 16'h0000
        ##1 chip_select_n && mem_data_oe == 16'h0000;
    endsequence
    property p_read_len;
        $fell(output_gate_n) |-> s_read_hold ##1 (output_gate_n && rsp_valid);
    endproperty
    a_read_len: assert property (p_read_len) else $error("read length wrong");
    property p_write_step;
        $fell(write_strobe_n) |-> output_gate_n && !chip_select_n ##1 s_write_end;
    endproperty
    a_write_step: assert property (p_write_step) else $error("write steps wrong");
    property p_write_end;
        $rose(write_strobe_n) |-> s_write_end;
    endproperty
    a_write_end: assert property (p_write_end) else $error("write end wrong");
    property p_write_hold;
        $rose(write_strobe_n) |-> $stable(mem_data_out);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("data not held");
    property p_read_strobe;
        !chip_select_n && !output_gate_n |-> write_strobe_n;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("strobe low in read");
    property p_no_clash;
        (!output_gate_n || chip_select_n) |-> mem_data_oe == 16'h0000;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("data driven in read");
    property p_addr_stable;
        !chip_select_n && !$fell(chip_select_n) |-> $stable(mem_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");
    property p_retain;
        retain_ok |-> chip_select_n;
    endproperty
    a_retain: assert property (p_retain) else $error("selected in retention");
    // Recovery keeps the memory deselected before the next access
    property p_recover;
        $fell(retain_ok) |-> chip_select_n ##1 chip_select_n;
    endproperty
    a_recover: assert property (p_recover) else $error("access too soon after retention");
    property p_rsp_pulse;
        rsp_valid |=> !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("long response");
endmodule
bind sram_ctrl sram_ctrl_asserts u_chk (.ref_clk(ref_clk), .reset(reset),
    .rsp_valid(rsp_valid), .retain_ok(retain_ok), .mem_addr(mem_addr),
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
`default_nettype wire

// ===== verif/sram_model.sv
// Behavioural model of the 256K x 16 asynchronous static RAM
`timescale 1ns/1ps
`default_nettype none
// ************
// Memory model
// ************
module sram_model (
    input wire logic [17:0] addr,
    input wire logic select_n,
    input wire logic gate_n,
    input wire logic strobe_n,
    input wire logic low_n,
    input wire logic high_n,
    input wire logic [15:0] host_data,
    input wire logic [15:0] host_oe,
    output logic [15:0] bus
);
    logic [15:0] store [0:262143];
    logic [15:0] dev_en;
    logic [15:0] last = 16'h0000;
    logic rd_on;
    logic write_on;
    int n_clash = 0;
    // Deselect, gate high or strobe low all float the pins
    assign rd_on = select_n === 1'b0 && gate_n === 1'b0 && strobe_n === 1'b1;
    assign dev_en = {{8{rd_on && high_n === 1'b0}}, {8{rd_on && low_n === 1'b0}}};
    assign write_on = select_n === 1'b0 && strobe_n === 1'b0;
    always @(negedge write_on) begin
        if (low_n === 1'b0) store[addr][7:0] = bus[7:0];
        if (high_n === 1'b0) store[addr][15:8] = bus[15:8];
    end
    // Released bits show the inverse so a stale value never passes
    always @(host_data or host_oe or dev_en or addr) begin
        for (int i = 0; i < 16; i++) begin
            if (host_oe[i] === 1'b1) last[i] = host_data[i];
            else if (dev_en[i] === 1'b1) last[i] = store[addr][i];
        end
        if ((host_oe & dev_en) != 16'h0000) n_clash++;
    end
    always @* begin
        for (int i = 0; i < 16; i++) begin
            bus[i] = host_oe[i] === 1'b1 ? host_data[i] :
                     dev_en[i] === 1'b1 ? store[addr][i] : ~last[i];
        end
    end
endmodule
`default_nettype wire

// ===== verif/async_sram_16bit_byte_lane_access_test.sv
// Self-checking bench for the static RAM controller
`timescale 1ns/1ps
`default_nettype none
// ************
// Bench top
// ************
module async_sram_16bit_byte_lane_access_test;
    logic ref_clk, reset, req_valid, req_write, req_ready, rsp_valid, retain_req, retain_ok;
    logic [17:0] req_addr, mem_addr;
    logic [15:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out, mem_data_oe, rd_seen;
    logic [1:0] req_lane_n;
    logic chip_select_n, output_gate_n, write_strobe_n, low_byte_lane_n, high_byte_lane_n;
    int n_mismatch = 0;
    int tests_run = 0;
    sram_ctrl dut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_n(req_lane_n), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
        .rsp_valid(rsp_valid), .retain_req(retain_req), .retain_ok(retain_ok),
        .mem_addr(mem_addr), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n), .low_byte_lane_n(low_byte_lane_n),
        .high_byte_lane_n(high_byte_lane_n), .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
    sram_model mem (.addr(mem_addr), .select_n(chip_select_n), .gate_n(output_gate_n),
        .strobe_n(write_strobe_n), .low_n(low_byte_lane_n), .high_n(high_byte_lane_n),
        .host_data(mem_data_out), .host_oe(mem_data_oe), .bus(mem_data_in));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Bounded wait for idle; catches the one-cycle read answer meanwhile
    task automatic wait_ready();
        int i;
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) begin
            if (rsp_valid === 1'b1) rd_seen = rsp_rdata;
            @(negedge ref_clk);
        end
        if (i == 40) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d,
                          input logic [1:0] ln);
        wait_ready();
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lane_n = ln;
        @(negedge ref_clk);
        req_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        wait_ready();
    endtask
    task automatic rd_check(input logic [17:0] a, input logic [1:0] ln, input logic [15:0] w);
        rd_seen = 16'hxxxx;
        access(1'b0, a, 16'h0000, ln);
        check(rd_seen, w);
    endtask
    task automatic t_lane_modes();
        logic [15:0] want [0:3] = '{16'hcdab, 16'hcd00, 16'h00ab, 16'h0000};
        access(1'b1, 18'h3ffff, 16'h1234, 2'b00);
        access(1'b1, 18'h3ffff, 16'h55ab, 2'b10);
        access(1'b1, 18'h3ffff, 16'hcd77, 2'b01);
        for (int k = 0; k < 4; k++) begin
            rd_check(18'h3ffff, 2'(k), want[k]);
        end
    endtask
    task automatic t_address_span();
        access(1'b1, 18'h00000, 16'h0f0f, 2'b00);
        rd_check(18'h00000, 2'b00, 16'h0f0f);
        rd_check(18'h3ffff, 2'b00, 16'hcdab);
    endtask
    // A write offered during retention must be dropped, not queued
    task automatic t_retention();
        int i;
        retain_req = 1'b1;
        for (i = 0; i < 20 && retain_ok !== 1'b1; i++) @(negedge ref_clk);
        if (i == 20) begin
            n_mismatch++;
            report_and_stop();
        end
        check({15'h0000, retain_ok}, 16'h0001);
        check({15'h0000, chip_select_n}, 16'h0001);
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 18'h00000;
        req_wdata = 16'h0000;
        req_lane_n = 2'b00;
        @(negedge ref_clk);
        req_valid = 1'b0;
        retain_req = 1'b0;
        rd_check(18'h00000, 2'b00, 16'h0f0f);
    endtask
    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 18'h00000;
        req_wdata = 16'h0000;
        req_lane_n = 2'b11;
        retain_req = 1'b0;
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        t_lane_modes();
        t_address_span();
        t_retention();
        check(16'(mem.n_clash), 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
